//--- verilog/fcr_top.v
// Floppy command interpreter: command bytes in, result bytes out, over APB.
// Assumes a sector engine on pclk and a drive fault pin from outside.
//
// Overview of operation
// - Register dump shows sectors-per-track after format, final sector after read/write.
// - Drive-select bits in parameters stay internal and drive no pins.
// - Read, write, verify share parameters and results; low opcode bits differ.
// - With implied seek enabled, data transfers seek first automatically.
// - Implied seek adds no host commands, parameters or result reads.
// - Addressed drive's busy flag is set during the implied seek.
// - Failed implied seek reports error in status, failing cylinder in C.
// - Read ID captures first good ID field, returns status and C,H,R,N.
// - Undefined code does nothing, enters standby, returns one byte 80H.
`timescale 1ns/10ps
`include "fcr_defs.vh"
module fcr_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  output reg step_out,
  output reg step_dir,
  output reg standby,
  input wire seek_fault_pin,
  output reg xfer_start,
  output reg [7:0] xfer_op,
  input wire xfer_done,
  input wire [7:0] xfer_st1,
  input wire [7:0] xfer_st2,
  input wire id_valid,
  input wire id_crc_ok,
  input wire [7:0] id_c,
  input wire [7:0] id_h,
  input wire [7:0] id_r,
  input wire [7:0] id_n
);
  localparam S_CMD = 3'd0;
  localparam S_PARM = 3'd1;
  localparam S_EXEC = 3'd2;
  localparam S_SEEK = 3'd3;
  localparam S_XFER = 3'd4;
  localparam S_RDID = 3'd5;
  localparam S_LOAD = 3'd6;
  localparam S_RES = 3'd7;
  localparam [31:0] STEP_FULL = `FCR_STEP_CYC - 1;
  localparam [31:0] STEP_MID = `FCR_STEP_CYC / 2;
  // Step counts fit ten bits; cut on purpose from the 32-bit figures
  localparam [9:0] STEP_LAST = STEP_FULL[9:0];
  localparam [9:0] STEP_HALF = STEP_MID[9:0];

  // Opcode classes; upper bits carry MT, MFM, SK, direction or lock
  function [3:0] cmd_class;
    input [7:0] b;
    begin
      if (b[4:0] == 5'h06 || b[4:0] == 5'h16 ||
          (b[5:0] == 6'h05))
        cmd_class = `FCR_C_RW;
      else if ({b[7], b[5:0]} == 7'h0d)
        cmd_class = `FCR_C_FMT;
      else if (b[7] && b[5:0] == 6'h0f)
        cmd_class = `FCR_C_RSEEK;
      else if (b == 8'h0f)
        cmd_class = `FCR_C_SEEK;
      else if (b == 8'h0e)
        cmd_class = `FCR_C_DUMP;
      else if ({b[7], b[5:0]} == 7'h0a)
        cmd_class = `FCR_C_RDID;
      else if (b == 8'h12)
        cmd_class = `FCR_C_PERP;
      else if (b[6:0] == 7'h14)
        cmd_class = `FCR_C_LOCK;
      else if (b == 8'h13)
        cmd_class = `FCR_C_CONF;
      else if (b == 8'h03)
        cmd_class = `FCR_C_SPEC;
      else
        cmd_class = `FCR_C_INVAL;
    end
  endfunction

  // Command length in bytes, opcode included
  function [3:0] cmd_len;
    input [3:0] c;
    begin
      case (c)
        `FCR_C_RW: cmd_len = 4'd9;
        `FCR_C_FMT: cmd_len = 4'd6;
        `FCR_C_RSEEK, `FCR_C_SEEK, `FCR_C_SPEC: cmd_len = 4'd3;
        `FCR_C_RDID, `FCR_C_PERP: cmd_len = 4'd2;
        `FCR_C_CONF: cmd_len = 4'd4;
        default: cmd_len = 4'd1;
      endcase
    end
  endfunction

  // Step count between present and wanted track, either direction
  function [7:0] track_dist;
    input [7:0] want;
    input [7:0] now;
    begin
      track_dist = (want > now) ? want - now : now - want;
    end
  endfunction

  reg [2:0] state_reg;
  reg [7:0] op_reg;
  reg [3:0] cls_reg;
  reg [3:0] pcnt_reg;
  reg [7:0] pbuf_reg [1:8];
  reg [7:0] pcn_reg [0:3];
  reg [7:0] spec1_reg, spec2_reg, sc_eot_reg, pretrk_reg;
  reg [5:0] perp_reg;
  reg [6:0] conf_reg;
  reg lock_reg;
  reg [7:0] st0_reg, st1_reg, st2_reg;
  reg [7:0] rc_reg, rh_reg, rr_reg, rn_reg;
  reg [7:0] steps_reg;
  reg [9:0] tick_reg;
  reg implied_reg;
  reg [3:0] idx_reg;
  reg [2:0] isr_reg, imr_reg;
  reg f1_reg, f2_reg, f3_reg, fault_reg;
  reg [7:0] res_byte;
  reg [3:0] res_len;
  reg [2:0] isr_next;
  integer i;
  wire [7:0] mem_rdata;
  wire [1:0] unit = pbuf_reg[1][1:0];
  wire head = pbuf_reg[1][2];
  wire [7:0] cur_pcn = pcn_reg[unit];
  wire cap = psel && penable && !pready;
  wire done = psel && penable && pready;
  wire wr_data = done && pwrite && paddr == `FCR_OFF_DATA;
  wire rd_data = done && !pwrite && paddr == `FCR_OFF_DATA;
  wire rd_isr = done && !pwrite && paddr == `FCR_OFF_ISR;
  wire in_res = state_reg == S_RES;
  wire rqm = state_reg == S_CMD || state_reg == S_PARM || in_res;
  wire [3:0] busy = (state_reg == S_SEEK) ? (4'h1 << unit) : 4'h0;
  wire [7:0] msr = {rqm, in_res, 1'b0, state_reg != S_CMD, busy};
  wire [7:0] hu = {5'h00, head, unit};
  wire [3:0] new_cls = cmd_class(pwdata[7:0]);

  fcr_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(state_reg == S_LOAD),
    .waddr(idx_reg),
    .wdata(res_byte),
    .raddr(idx_reg),
    .rdata(mem_rdata)
  );

  // Result image, one byte per index, chosen by command class
  always @*
  begin
    res_byte = 8'h00;
    res_len = 4'd7;
    case (cls_reg)
      `FCR_C_DUMP:
      begin
        res_len = 4'd10;
        case (idx_reg)
          4'd0, 4'd1, 4'd2, 4'd3: res_byte = pcn_reg[idx_reg[1:0]];
          4'd4: res_byte = spec1_reg;
          4'd5: res_byte = spec2_reg;
          4'd6: res_byte = sc_eot_reg;
          4'd7: res_byte = {lock_reg, 1'b0, perp_reg};
          4'd8: res_byte = {1'b0, conf_reg};
          4'd9: res_byte = pretrk_reg;
          default: res_byte = 8'h00;
        endcase
      end
      `FCR_C_LOCK:
      begin
        res_len = 4'd1;
        res_byte = {3'b000, lock_reg, 4'h0};
      end
      `FCR_C_INVAL:
      begin
        res_len = 4'd1;
        res_byte = `FCR_ST0_INVAL;
      end
      default:
      begin
        // Seven-byte status and ID shape shared by transfers and read ID
        case (idx_reg)
          4'd0: res_byte = st0_reg;
          4'd1: res_byte = st1_reg;
          4'd2: res_byte = st2_reg;
          4'd3: res_byte = rc_reg;
          4'd4: res_byte = rh_reg;
          4'd5: res_byte = rr_reg;
          4'd6: res_byte = rn_reg;
          default: res_byte = 8'h00;
        endcase
      end
    endcase
  end

  // Fault pin: three flops, accepted once stages two and three agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      f1_reg <= 1'b0;
      f2_reg <= 1'b0;
      f3_reg <= 1'b0;
      fault_reg <= 1'b0;
    end
    else
    begin
      f1_reg <= seek_fault_pin;
      f2_reg <= f1_reg;
      f3_reg <= f2_reg;
      if (f2_reg == f3_reg)
        fault_reg <= f3_reg;
    end
  end

  // APB slave: one wait state, read data registered on the same edge that raises pready
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      imr_reg <= `FCR_IMR_RST;
    end
    else
    begin
      pready <= cap;
      if (cap)
      begin
        pslverr <= paddr[7:4] != 4'h0 || paddr[1:0] != 2'b00;
        case (paddr)
          `FCR_OFF_DATA: prdata <= {24'h00_0000, mem_rdata};
          `FCR_OFF_MSR: prdata <= {24'h00_0000, msr};
          `FCR_OFF_ISR: prdata <= {29'h0000_0000, isr_reg};
          `FCR_OFF_IMR: prdata <= {29'h0000_0000, imr_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (done && pwrite && paddr == `FCR_OFF_IMR)
        imr_reg <= pwdata[2:0];
    end
  end

  // Interrupt status: a set in the clearing cycle survives
  always @*
  begin
    isr_next = isr_reg & ~(rd_isr ? prdata[2:0] : 3'h0);
    if (state_reg == S_LOAD && idx_reg == res_len - 4'd1)
      isr_next[`FCR_IRQ_DONE] = 1'b1;
    if (state_reg == S_CMD && wr_data && new_cls == `FCR_C_INVAL)
      isr_next[`FCR_IRQ_INVAL] = 1'b1;
    if (state_reg == S_SEEK && !implied_reg &&
        (fault_reg || steps_reg == 8'h00))
      isr_next[`FCR_IRQ_SEEK] = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      isr_reg <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      isr_reg <= isr_next;
      irq <= |(isr_next & imr_reg);
    end
  end

  // Command sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= S_CMD;
      op_reg <= 8'h00;
      cls_reg <= `FCR_C_INVAL;
      pcnt_reg <= 4'd0;
      for (i = 1; i <= 8; i = i + 1)
        pbuf_reg[i] <= 8'h00;
      for (i = 0; i < 4; i = i + 1)
        pcn_reg[i] <= 8'h00;
      spec1_reg <= `FCR_SPEC_RST;
      spec2_reg <= `FCR_SPEC_RST;
      sc_eot_reg <= 8'h00;
      pretrk_reg <= `FCR_PRETRK_RST;
      perp_reg <= 6'h00;
      conf_reg <= `FCR_CONF_RST;
      lock_reg <= 1'b0;
      st0_reg <= 8'h00;
      st1_reg <= 8'h00;
      st2_reg <= 8'h00;
      rc_reg <= 8'h00;
      rh_reg <= 8'h00;
      rr_reg <= 8'h00;
      rn_reg <= 8'h00;
      steps_reg <= 8'h00;
      tick_reg <= 10'd0;
      implied_reg <= 1'b0;
      idx_reg <= 4'd0;
      step_out <= 1'b0;
      step_dir <= 1'b0;
      standby <= 1'b0;
      xfer_start <= 1'b0;
      xfer_op <= 8'h00;
    end
    else
    begin
      xfer_start <= 1'b0;
      case (state_reg)
        S_CMD:
          if (wr_data)
          begin
            op_reg <= pwdata[7:0];
            cls_reg <= new_cls;
            pcnt_reg <= 4'd1;
            idx_reg <= 4'd0;
            standby <= new_cls == `FCR_C_INVAL;
            if (new_cls == `FCR_C_INVAL)
              state_reg <= S_LOAD;
            else if (cmd_len(new_cls) == 4'd1)
              state_reg <= S_EXEC;
            else
              state_reg <= S_PARM;
          end
        S_PARM:
          if (wr_data)
          begin
            pbuf_reg[pcnt_reg] <= pwdata[7:0];
            pcnt_reg <= pcnt_reg + 4'd1;
            if (pcnt_reg == cmd_len(cls_reg) - 4'd1)
              state_reg <= S_EXEC;
          end
        S_EXEC:
        begin
          state_reg <= S_CMD;
          implied_reg <= 1'b0;
          tick_reg <= 10'd0;
          case (cls_reg)
            `FCR_C_SPEC:
            begin
              spec1_reg <= pbuf_reg[1];
              spec2_reg <= pbuf_reg[2];
            end
            `FCR_C_CONF:
            begin
              conf_reg <= pbuf_reg[2][6:0];
              pretrk_reg <= pbuf_reg[3];
            end
            `FCR_C_PERP:
            begin
              // Drive bits change only with the overwrite bit set
              perp_reg[1:0] <= pbuf_reg[1][1:0];
              if (pbuf_reg[1][7])
                perp_reg[5:2] <= pbuf_reg[1][5:2];
            end
            `FCR_C_LOCK:
            begin
              lock_reg <= op_reg[7];
              state_reg <= S_LOAD;
            end
            `FCR_C_DUMP: state_reg <= S_LOAD;
            `FCR_C_RDID: state_reg <= S_RDID;
            `FCR_C_RSEEK:
            begin
              steps_reg <= pbuf_reg[2];
              step_dir <= op_reg[6];
              state_reg <= S_SEEK;
            end
            `FCR_C_SEEK:
            begin
              step_dir <= pbuf_reg[2] > cur_pcn;
              steps_reg <= track_dist(pbuf_reg[2], cur_pcn);
              state_reg <= S_SEEK;
            end
            `FCR_C_FMT:
            begin
              sc_eot_reg <= pbuf_reg[3];
              xfer_start <= 1'b1;
              xfer_op <= op_reg;
              state_reg <= S_XFER;
            end
            `FCR_C_RW:
            begin
              sc_eot_reg <= pbuf_reg[6];
              xfer_op <= op_reg;
              if (conf_reg[6] && pbuf_reg[2] != cur_pcn)
              begin
                // Hidden seek reuses the transfer's own parameters
                implied_reg <= 1'b1;
                step_dir <= pbuf_reg[2] > cur_pcn;
                steps_reg <= track_dist(pbuf_reg[2], cur_pcn);
                state_reg <= S_SEEK;
              end
              else
              begin
                xfer_start <= 1'b1;
                state_reg <= S_XFER;
              end
            end
            default: state_reg <= S_CMD;
          endcase
        end
        S_SEEK:
        begin
          // Fault is checked before each step, so C is the failing track
          if (fault_reg)
          begin
            step_out <= 1'b0;
            if (implied_reg)
            begin
              st0_reg <= `FCR_ST0_ABN | `FCR_ST0_EQUIP | hu;
              st1_reg <= 8'h00;
              st2_reg <= 8'h00;
              rc_reg <= cur_pcn;
              rh_reg <= pbuf_reg[3];
              rr_reg <= pbuf_reg[4];
              rn_reg <= pbuf_reg[5];
              state_reg <= S_LOAD;
            end
            else
              state_reg <= S_CMD;
          end
          else if (steps_reg == 8'h00)
          begin
            if (implied_reg)
            begin
              xfer_start <= 1'b1;
              state_reg <= S_XFER;
            end
            else
              state_reg <= S_CMD;
          end
          else
          begin
            step_out <= tick_reg < STEP_HALF;
            if (tick_reg == STEP_LAST)
            begin
              tick_reg <= 10'd0;
              steps_reg <= steps_reg - 8'h01;
              pcn_reg[unit] <= step_dir ? cur_pcn + 8'h01 :
                cur_pcn - 8'h01;
            end
            else
              tick_reg <= tick_reg + 10'd1;
          end
        end
        S_XFER:
          if (xfer_done)
          begin
            st0_reg <= (xfer_st1 != 8'h00 || xfer_st2 != 8'h00) ?
              (`FCR_ST0_ABN | hu) : hu;
            st1_reg <= xfer_st1;
            st2_reg <= xfer_st2;
            rc_reg <= pbuf_reg[2];
            rh_reg <= pbuf_reg[3];
            rr_reg <= pbuf_reg[4];
            rn_reg <= pbuf_reg[5];
            state_reg <= S_LOAD;
          end
        S_RDID:
          // Bad-CRC fields pass by; the first good one is kept
          if (id_valid && id_crc_ok)
          begin
            st0_reg <= hu;
            st1_reg <= 8'h00;
            st2_reg <= 8'h00;
            rc_reg <= id_c;
            rh_reg <= id_h;
            rr_reg <= id_r;
            rn_reg <= id_n;
            state_reg <= S_LOAD;
          end
        S_LOAD:
          if (idx_reg == res_len - 4'd1)
          begin
            idx_reg <= 4'd0;
            state_reg <= S_RES;
          end
          else
            idx_reg <= idx_reg + 4'd1;
        S_RES:
          if (rd_data)
          begin
            idx_reg <= idx_reg + 4'd1;
            if (idx_reg == res_len - 4'd1)
              state_reg <= S_CMD;
          end
        default: state_reg <= S_CMD;
      endcase
    end
  end
endmodule // fcr_top

//--- verilog/fcr_defs.vh
// Constants for the floppy command and result handler.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef FCR_DEFS_VH
`define FCR_DEFS_VH
// APB register byte offsets
`define FCR_OFF_DATA 8'h00
`define FCR_OFF_MSR 8'h04
`define FCR_OFF_ISR 8'h08
`define FCR_OFF_IMR 8'h0c
// Interrupt status bit positions
`define FCR_IRQ_DONE 0
`define FCR_IRQ_INVAL 1
`define FCR_IRQ_SEEK 2
// Main status bit positions
`define FCR_MSR_RQM 7
`define FCR_MSR_DIO 6
`define FCR_MSR_CB 4
// First status byte values
`define FCR_ST0_INVAL 8'h80
`define FCR_ST0_ABN 8'h40
`define FCR_ST0_SEEKEND 8'h20
`define FCR_ST0_EQUIP 8'h10
// Reset values
`define FCR_CONF_RST 7'h00
`define FCR_PRETRK_RST 8'h00
`define FCR_SPEC_RST 8'h00
`define FCR_IMR_RST 3'h0
// Command classes
`define FCR_C_INVAL 4'h0
`define FCR_C_RW 4'h1
`define FCR_C_FMT 4'h2
`define FCR_C_RSEEK 4'h3
`define FCR_C_SEEK 4'h4
`define FCR_C_DUMP 4'h5
`define FCR_C_RDID 4'h6
`define FCR_C_PERP 4'h7
`define FCR_C_LOCK 4'h8
`define FCR_C_CONF 4'h9
`define FCR_C_SPEC 4'ha
// Step timing: period in ns, clock period in ns, cycles rounded up
`define FCR_STEP_NS 3000
`define FCR_CLK_NS 5
`define FCR_STEP_CYC ((`FCR_STEP_NS + `FCR_CLK_NS - 1) / `FCR_CLK_NS)
`endif

//--- verilog/fcr_mem.v
// Result byte store: 16 bytes, one write port, registered read.
// Assumes the writer and reader share pclk.
`timescale 1ns/10ps
module fcr_mem (
  input wire pclk,
  input wire presetn,
  input wire we,
  input wire [3:0] waddr,
  input wire [7:0] wdata,
  input wire [3:0] raddr,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:15];

  // Array holds no reset; only the read register does
  always @(posedge pclk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // Read data leaves through a flop, one cycle after the address
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata <= 8'h00;
    else
      rdata <= mem[raddr];
  end
endmodule // fcr_mem

//--- verification/fcr_checker.sv
// Concurrent checks on the command handler's APB side, step and standby pins.
// Assumes binding into fcr_top; all checks sleep while presetn is low.
`timescale 1ns/10ps
module fcr_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire step_out,
  input wire standby,
  input wire xfer_start
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] hi_cnt;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence acc_s;
    psel && penable && pready;
  endsequence
  // Length of the current step pulse, so its width is checked exactly
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hi_cnt <= 10'h000;
    else if (step_out)
      hi_cnt <= hi_cnt + 10'h001;
    else
      hi_cnt <= 10'h000;
  end
  wait_state_a: assert property (setup_s |=> !pready ##1 pready)
    else $error("pready not after one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  bad_addr_a: assert property (acc_s ##0
    (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access without pslverr");
  good_addr_a: assert property (acc_s ##0
    (paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("mapped access with pslverr");
  inval_idle_a: assert property ($rose(standby) |->
    (!xfer_start && !step_out)[*8])
    else $error("activity after undefined code");
  busy_seek_a: assert property (acc_s ##0 (!pwrite && paddr == 8'h04
    && step_out && $past(step_out)) |-> prdata[0])
    else $error("drive busy flag low while stepping");
  step_len_a: assert property ($fell(step_out) |-> hi_cnt == 10'd300)
    else $error("step pulse width wrong");
  xfer_pulse_a: assert property (xfer_start |=> !xfer_start)
    else $error("transfer start longer than one cycle");
endmodule // fcr_checker

bind fcr_top fcr_checker chk_u (.*);

//--- verification/fcr_eng.sv
// Sector engine stand-in: answers transfer starts and streams ID fields.
// Assumes the bench chooses latency and an error through slow and bad.
`timescale 1ns/10ps
module fcr_eng #(
  parameter logic [7:0] id_cyl = 8'h21,
  parameter logic [7:0] id_rec = 8'h07
) (
  input wire pclk,
  input wire presetn,
  input wire xfer_start,
  input wire slow,
  input wire bad,
  output logic xfer_done,
  output logic [7:0] xfer_st1,
  output logic [7:0] xfer_st2,
  output logic id_valid,
  output logic id_crc_ok,
  output logic [7:0] id_c,
  output logic [7:0] id_h,
  output logic [7:0] id_r,
  output logic [7:0] id_n
);
  logic [7:0] wait_cnt;
  logic [7:0] tick;
  // Count down to the transfer end; an ID field passes every 16 cycles
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cnt <= 8'h00;
      tick <= 8'h00;
    end
    else
    begin
      tick <= tick + 8'h01;
      if (xfer_start)
        wait_cnt <= slow ? 8'h50 : 8'h04;
      else if (wait_cnt != 8'h00)
        wait_cnt <= wait_cnt - 8'h01;
    end
  end
  // Fields are good only while valid; a drifting pattern hides stale values
  assign xfer_done = (wait_cnt == 8'h01);
  assign xfer_st1 = xfer_done ? {5'h00, bad, 2'h0} : ~tick;
  assign xfer_st2 = xfer_done ? 8'h00 : tick;
  assign id_valid = (tick[3:0] == 4'hf);
  assign id_crc_ok = tick[4];
  assign id_c = !id_valid ? tick : id_crc_ok ? id_cyl : 8'hee;
  assign id_h = id_valid ? 8'h00 : ~tick;
  assign id_r = !id_valid ? tick : id_crc_ok ? id_rec : 8'hee;
  assign id_n = id_valid ? 8'h02 : ~tick;
endmodule // fcr_eng

//--- verification/testbench.sv
// Self-checking bench: APB host tasks drive commands and read results.
// Assumes fcr_top with the engine model and the bound checker.
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] id_cyl = 8'h21;
  localparam logic [7:0] id_rec = 8'h07;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, fault = 1'b0, slow = 1'b0, bad = 1'b0, se;
  logic [7:0] paddr = 8'h00, final_sector_number, p0;
  logic [31:0] pwdata = 32'h0000_0000, rd, pv;
  logic [7:0] res_b [10];
  logic [7:0] cq [$];
  logic [7:0] ops [3] = '{8'h46, 8'hc5, 8'h16};
  int err_count = 0, comparisons = 0, k;
  wire [31:0] prdata;
  wire pready, pslverr, irq, standby, xs, xd, iv, ic, sd;
  wire [7:0] xo, s1, s2, c, h, r, n;
  always #2.5 pclk = ~pclk;
  fcr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .step_out(), .step_dir(sd), .standby(standby), .seek_fault_pin(fault),
    .xfer_start(xs), .xfer_op(xo), .xfer_done(xd), .xfer_st1(s1),
    .xfer_st2(s2), .id_valid(iv), .id_crc_ok(ic), .id_c(c), .id_h(h),
    .id_r(r), .id_n(n));
  fcr_eng #(.id_cyl(id_cyl), .id_rec(id_rec)) eng_u (.pclk(pclk),
    .presetn(presetn), .xfer_start(xs), .slow(slow), .bad(bad),
    .xfer_done(xd), .xfer_st1(s1), .xfer_st2(s2), .id_valid(iv),
    .id_crc_ok(ic), .id_c(c), .id_h(h), .id_r(r), .id_n(n));
  task automatic close_out();
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sends the queued command bytes in order, one data register write each
  task automatic snd();
    foreach (cq[i]) apb(1'b1, 8'h00, {24'h00_0000, cq[i]});
  endtask
  // Waits for the result phase, then pops cnt result bytes
  task automatic res(input int cnt);
    k = 0;
    do
    begin
      apb(1'b0, 8'h04, 32'h0000_0000);
      k++;
    end
    while (rd[6] !== 1'b1 && k < 3000);
    chk("res ready", rd[6], 1'b1);
    for (int i = 0; i < cnt; i++)
    begin
      apb(1'b0, 8'h00, 32'h0000_0000);
      res_b[i] = rd[7:0];
    end
  endtask
  // Watchdog: the sequence needs well under 40000 cycles
  initial
  begin
    #400000;
    err_count++;
    close_out();
  end
  initial
  begin
    pv = $urandom(7);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk("imr", rd, 32'h0000_0000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("msr", rd, 32'h0000_0080);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("slverr", se, 1'b1);
    apb(1'b1, 8'h0c, 32'h0000_0001);
    // Lock both ways; the done interrupt is raised, then cleared by a read
    for (int v = 0; v < 2; v++)
    begin
      cq = {{v[0], 7'h14}};
      snd();
      res(1);
      chk("lock", res_b[0], {3'h0, v[0], 4'h0});
      chk("irq", irq, 1'b1);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk("isr", rd[0], 1'b1);
      repeat (2) @(posedge pclk);
      chk("irq", irq, 1'b0);
    end
    // Undefined codes with every interrupt masked
    apb(1'b1, 8'h0c, 32'h0000_0000);
    foreach (ops[i])
    begin
      cq = {i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'h1f};
      snd();
      res(1);
      chk("inval", res_b[0], 8'h80);
      chk("standby", standby, 1'b1);
      chk("irq", irq, 1'b0);
    end
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("isr", rd[1], 1'b1);
    // Read, write and verify codes, random fields, one engine error
    foreach (ops[i])
    begin
      pv = $urandom;
      final_sector_number = pv[31:24];
      slow <= pv[0];
      bad <= (i == 1);
      cq = {ops[i], 8'h00, 8'h00, pv[7:0], pv[15:8], pv[23:16], final_sector_number,
        8'h1b, 8'hff};
      snd();
      res(7);
      chk("st0", res_b[0], i == 1 ? 8'h40 : 8'h00);
      chk("st1", res_b[1], i == 1 ? 8'h04 : 8'h00);
      for (int j = 3; j < 7; j++) chk("chrn", res_b[j], cq[j - 1]);
      chk("op", xo, ops[i]);
    end
    cq = {8'h0e};
    snd();
    res(10);
    chk("dump eot", res_b[6], final_sector_number);
    pv = $urandom;
    cq = {8'h4d, 8'h00, 8'h02, pv[7:0], 8'h1b, 8'he5};
    snd();
    res(7);
    cq = {8'h0e};
    snd();
    res(10);
    chk("dump sc", res_b[6], pv[7:0]);
    cq = {8'h4a, 8'h00};
    snd();
    res(7);
    chk("id c", res_b[3], id_cyl);
    chk("id r", res_b[5], id_rec);
    chk("id h", res_b[4], 8'h00);
    chk("id n", res_b[6], 8'h02);
    // Implied seek to track 2, then a failing one toward track 5
    bad <= 1'b0;
    cq = {8'h13, 8'h00, 8'h40, 8'h00};
    snd();
    for (int f = 0; f < 2; f++)
    begin
      fault <= f[0];
      cq = {8'h46, 8'h00, f ? 8'h05 : 8'h02, 8'h00, 8'h01, 8'h02, 8'h09,
        8'h1b, 8'hff};
      snd();
      repeat (10) @(posedge pclk);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("busy", rd[0], f ? 1'b0 : 1'b1);
      res(7);
      chk("seek st0", res_b[0], f ? 8'h50 : 8'h00);
      chk("seek c", res_b[3], 8'h02);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("msr", rd, 32'h0000_0080);
    end
    fault <= 1'b0;
    // Relative seeks out by three and back by one
    for (int d = 0; d < 2; d++)
    begin
      cq = {d ? 8'h8f : 8'hcf, 8'h00, d ? 8'h01 : 8'h03};
      snd();
      k = 0;
      do
      begin
        apb(1'b0, 8'h08, 32'h0000_0000);
        k++;
      end
      while (rd[2] !== 1'b1 && k < 3000);
      chk("seek end", rd[2], 1'b1);
      chk("dir", sd, d ? 1'b0 : 1'b1);
      cq = {8'h0e};
      snd();
      res(10);
      chk("track", res_b[0], d ? 8'h04 : 8'h05);
    end
    close_out();
  end
endmodule // testbench
